// ==== inc/acr_pkg.sv ====
// constants and types for the converter start and serial readout block
// assumes a 40 MHz system clock and a host that owns the serial shift clock
package acr_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 25;
   // fixed conversion time, placed between the shortest and longest times
   localparam int CONV_TIME_NS = 600;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int CONV_CNT_BITS = 8;
   localparam logic [CONV_CNT_BITS-1:0] CONV_LAST = CONV_CNT_BITS'(CONV_CYCLES - 1);
   localparam logic [CONV_CNT_BITS-1:0] CONV_CNT_RESET = 8'h00;

   // ----------------------------------------------------------------
   // word and edge counts
   // ----------------------------------------------------------------
   localparam int RESULT_BITS = 16;
   localparam int WORD_BITS = 17;
   localparam int WORD_MSB = 16;
   localparam int EDGE_BITS = 6;
   localparam logic [EDGE_BITS-1:0] EDGES_PLAIN = 6'h10;
   localparam logic [EDGE_BITS-1:0] EDGES_BUSY = 6'h11;
   localparam logic [EDGE_BITS-1:0] EDGE_RESET = 6'h00;
   localparam logic [WORD_BITS-1:0] WORD_RESET = 17'h00000;
   localparam int PIN_SYNC_BITS = 3;

   // ----------------------------------------------------------------
   // control states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_WAIT_SEL,
      ST_SHIFT
   } acr_state_t;

endpackage : acr_pkg

// ==== test/acr_host.sv ====
// host-side model: owns the shift clock, feeds chain data, reads the data line
// assumes the line is already resolved with its pull-up by the bench
`timescale 1ns/100ps
module acr_host (
   input wire logic line,
   output logic serial_shift_clock,
   output logic up_bit,
   output logic [47:0] captured
);
   initial begin
      serial_shift_clock = 1'b0;
      up_bit = 1'b1;
      captured = 48'h000000000000;
   end

   // ----------------------------------------------------------------
   // clock level between frames
   // ----------------------------------------------------------------
   task set_idle(input logic lvl);
      serial_shift_clock = lvl;
   endtask : set_idle

   // ----------------------------------------------------------------
   // n falling edges 80 ns apart, line read just before each fall
   // ----------------------------------------------------------------
   task burst(input int n, input logic [15:0] up);
      int k;
      captured = 48'h000000000000;
      #7;
      for (k = 0; k < n; k++) begin
         up_bit = up[15];
         serial_shift_clock = 1'b1;
         #40;
         captured = {captured[46:0], line};
         serial_shift_clock = 1'b0;
         up = {up[14:0], ~up[0]};
         #40;
      end
      // released chain data must not look like a held bit
      up_bit = ~up_bit;
   endtask : burst
endmodule : acr_host

// ==== test/adc_conversion_serial_readout_bench.sv ====
// self-checking bench for the converter start and serial readout block
// assumes the line has a pull-up, so high impedance reads as 1
`timescale 1ns/100ps
module adc_conversion_serial_readout_bench;
   logic clock, reset_n, convert_start, sel_b, chain_rd, sck, line, up_bit;
   logic serial_select_in, serial_result_out, serial_result_oe, converting;
   logic [15:0] conv_data, seed, d, u;
   logic [47:0] captured, pins;
   int num_errors, num_checks, cycles;

   assign serial_select_in = chain_rd ? up_bit : sel_b;
   assign line = serial_result_oe ? serial_result_out : 1'b1;
   assign pins = {46'h000000000000, serial_result_oe, line};

   acr_readout acr_readout_i (
      .clock(clock),
      .reset_n(reset_n),
      .serial_shift_clock(sck),
      .convert_start(convert_start),
      .serial_select_in(serial_select_in),
      .conv_data(conv_data),
      .serial_result_out(serial_result_out),
      .serial_result_oe(serial_result_oe),
      .converting(converting)
   );
   acr_host acr_host_i (
      .line(line),
      .serial_shift_clock(sck),
      .up_bit(up_bit),
      .captured(captured)
   );

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task give_verdict();
      if (num_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   // about 30 frames of under 300 cycles each
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end

   task chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   // modes: 0 four-wire plain, 1 four-wire busy, 2 three-wire busy,
   // 3 chain plain, 4 chain busy; busy words lead with their start bit
   function automatic logic [47:0] expect_word(input int m, input logic [15:0] dd,
                                               input logic [15:0] uu);
      case (m)
         0, 1, 2: return {32'h00000000, dd};
         3: return {16'h0000, dd, uu};
         default: return {15'h0000, 1'b1, dd, uu};
      endcase
   endfunction : expect_word

   // ----------------------------------------------------------------
   // one conversion and readout
   // ----------------------------------------------------------------
   task frame(input int m, input logic abort);
      int n, full, k;
      logic chain;
      chain = (m >= 3);
      full = (m == 0) ? 16 : (m < 3) ? 17 : (m == 3) ? 32 : 33;
      n = abort ? 5 : full;
      sel_b = !chain;
      convert_start = 1'b0;
      acr_host_i.set_idle(m == 4);
      cyc(4);
      if (chain) chk(pins, 48'h2, "idle drive low");
      d = seed;
      seed = lfsr_next(seed);
      u = seed;
      seed = lfsr_next(seed);
      conv_data = d;
      convert_start = 1'b1;
      k = 0;
      while (converting !== 1'b1 && k < 8) begin
         cyc(1);
         k++;
      end
      chk(pins, 48'h1, "tristate at start");
      k = 0;
      while (converting === 1'b1 && k < 100) begin
         if (k == 4 && m == 1) sel_b = 1'b0;
         if (k == 4 && m == 2) convert_start = 1'b0;
         chk(pins, 48'h1, "tristate in conversion");
         cyc(1);
         k++;
      end
      chk(48'(k), 48'(acr_pkg::CONV_CYCLES), "conversion length");
      cyc(3);
      if (m == 0) begin
         chk(pins, 48'h1, "no start bit");
         sel_b = 1'b0;
         cyc(4);
      end
      chk(pins, (m == 0 || m == 3) ? {46'h0, 1'b1, d[15]} : (m == 4) ? 48'h3 : 48'h2,
          "ready level");
      chain_rd = chain;
      acr_host_i.burst(n, u);
      chain_rd = 1'b0;
      chk(captured, expect_word(m, d, u) >> (full - n), "shifted word");
      if (abort) convert_start = 1'b1;
      cyc(6);
      if (!chain) chk(pins, 48'h1, "end of readout");
      if (abort) begin
         // the restart converts with select high: read it as a 3-wire plain frame
         cyc(30);
         convert_start = 1'b0;
         cyc(4);
         chk(pins, {46'h0, 1'b1, d[15]}, "3-wire msb at select");
         acr_host_i.burst(16, u);
         chk(captured, {32'h00000000, d}, "3-wire word");
         cyc(6);
         chk(pins, 48'h1, "3-wire end");
      end
      convert_start = 1'b0;
      if (chain) begin
         cyc(4);
         chk(pins, 48'h2, "chain ended low");
      end
      sel_b = 1'b1;
      cyc(4);
   endtask : frame

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      convert_start = 1'b0;
      sel_b = 1'b1;
      chain_rd = 1'b0;
      conv_data = 16'h0000;
      seed = 16'h6D06;
      num_errors = 0;
      num_checks = 0;
      cycles = 0;
      cyc(3);
      reset_n = 1'b1;
      cyc(4);
      for (int r = 0; r < 6; r++) begin
         for (int m = 0; m < 5; m++) begin
            frame(m, (m == 2) && r[0]);
         end
      end
      give_verdict();
   end
endmodule : adc_conversion_serial_readout_bench

// ==== verilog/acr_edge_tap.sv ====
// serial clock domain: counts falling edges and samples the chain input
// assumes the host clock may stop between frames; nothing here needs an idle edge
`timescale 1ns/100ps
module acr_edge_tap (
   input wire logic serial_shift_clock,
   input wire logic reset_n,
   input wire logic serial_select_in,
   output logic [acr_pkg::EDGE_BITS-1:0] edge_gray,
   output logic [1:0] sample_hist
);
   logic [acr_pkg::EDGE_BITS-1:0] edge_bin;
   logic [acr_pkg::EDGE_BITS-1:0] next_edge_bin;

   assign next_edge_bin = edge_bin + 6'h01;

   // two-entry history: a sample is read by the other domain one edge
   // later and is not overwritten until two edges after it was taken
   always_ff @(negedge serial_shift_clock or negedge reset_n) begin
      if (!reset_n) begin
         edge_bin <= acr_pkg::EDGE_RESET;
         edge_gray <= acr_pkg::EDGE_RESET;
         sample_hist <= 2'h0;
      end else begin
         edge_bin <= next_edge_bin;
         edge_gray <= next_edge_bin ^ (next_edge_bin >> 1);
         sample_hist[edge_bin[0]] <= serial_select_in;
      end
   end
endmodule : acr_edge_tap

// ==== verilog/acr_readout.sv ====
// conversion start, mode capture and serial result readout for one channel
// assumes pins arrive asynchronously; conv_data is the result, stable at completion
`timescale 1ns/100ps

// How it works
// - convert rise latches select level as mode
// - select busy bit if either line low
// - select high rise: convert, select mode, tristate
// - output stays tristate until conversion completes
// - busy: output driven at completion, start bit
// - bits leave msb first on falling edges
// - 3-wire busy: tristate after 17 edges
// - select and convert both low drive low
// - 4-wire plain: select low shows msb
// - 4-wire plain: tristate after 16 edges
// - 4-wire busy: tristate after 17 edges
// - clock low at rise: chain, no busy
// - clock high at rise: chain with busy
// - chain plain: msb shown at completion
// - chain input feeds shift register each edge
// - chain busy: drive high once converted
module acr_readout (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic serial_shift_clock,
   input wire logic convert_start,
   input wire logic serial_select_in,
   input wire logic [acr_pkg::RESULT_BITS-1:0] conv_data,
   output logic serial_result_out,
   output logic serial_result_oe,
   output logic converting
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      acr_pkg::acr_state_t st;
      logic cnv_d;
      logic mode_cs;
      logic chain_busy;
      logic busy;
      logic [acr_pkg::CONV_CNT_BITS-1:0] conv_cnt;
      logic [acr_pkg::WORD_BITS-1:0] word;
      logic [acr_pkg::EDGE_BITS-1:0] seen;
      logic [acr_pkg::EDGE_BITS-1:0] shifted;
      logic out;
      logic oe;
      logic converting;
   } acr_regs_t;

   localparam acr_regs_t REGS_RESET = '{
      st: acr_pkg::ST_IDLE,
      cnv_d: 1'b0,
      mode_cs: 1'b0,
      chain_busy: 1'b0,
      busy: 1'b0,
      conv_cnt: acr_pkg::CONV_CNT_RESET,
      word: acr_pkg::WORD_RESET,
      seen: acr_pkg::EDGE_RESET,
      shifted: acr_pkg::EDGE_RESET,
      out: 1'b0,
      oe: 1'b0,
      converting: 1'b0
   };

   acr_regs_t s;
   acr_regs_t next_s;

   // ----------------------------------------------------------------
   // crossings
   // ----------------------------------------------------------------
   logic [acr_pkg::PIN_SYNC_BITS-1:0] pins_sync;
   logic [acr_pkg::EDGE_BITS-1:0] edge_gray;
   logic [acr_pkg::EDGE_BITS-1:0] edge_gray_sync;
   logic [1:0] sample_hist;
   logic cnv;
   logic sdi;
   logic sck_level;

   // the shift clock is also sampled as a level to pick the chain variant
   acr_sync #(.WIDTH(acr_pkg::PIN_SYNC_BITS)) u_pin_sync (
      .clock(clock),
      .reset_n(reset_n),
      .d({serial_shift_clock, serial_select_in, convert_start}),
      .q(pins_sync)
   );

   acr_edge_tap u_edge_tap (
      .serial_shift_clock(serial_shift_clock),
      .reset_n(reset_n),
      .serial_select_in(serial_select_in),
      .edge_gray(edge_gray),
      .sample_hist(sample_hist)
   );

   acr_sync #(.WIDTH(acr_pkg::EDGE_BITS)) u_edge_sync (
      .clock(clock),
      .reset_n(reset_n),
      .d(edge_gray),
      .q(edge_gray_sync)
   );

   assign cnv = pins_sync[0];
   assign sdi = pins_sync[1];
   assign sck_level = pins_sync[2];

   function automatic logic [acr_pkg::EDGE_BITS-1:0] gray_to_bin(
      input logic [acr_pkg::EDGE_BITS-1:0] g
   );
      logic [acr_pkg::EDGE_BITS-1:0] b;
      b = g;
      for (int i = acr_pkg::EDGE_BITS - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : gray_to_bin

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic [acr_pkg::EDGE_BITS-1:0] edge_cnt;
   logic cnv_rise;
   logic sel;
   logic step;
   logic conv_end;
   logic [acr_pkg::EDGE_BITS-1:0] limit;
   logic chain_bit;

   assign edge_cnt = gray_to_bin(edge_gray_sync);
   assign cnv_rise = cnv && !s.cnv_d;
   // a channel is selected unless both convert and select are high
   assign sel = !(cnv && sdi);
   // edges are consumed one per cycle, so a burst is caught up, not lost
   assign step = (s.seen != edge_cnt);
   assign conv_end = (s.st == acr_pkg::ST_CONVERT) && (s.conv_cnt == acr_pkg::CONV_LAST);
   assign limit = s.busy ? acr_pkg::EDGES_BUSY : acr_pkg::EDGES_PLAIN;
   assign chain_bit = sample_hist[s.seen[0]];

   always_comb begin
      next_s = s;
      next_s.cnv_d = cnv;
      case (s.st)
         acr_pkg::ST_IDLE: begin
            next_s.oe = !cnv && !sdi;
            next_s.out = 1'b0;
         end
         acr_pkg::ST_CONVERT: begin
            next_s.oe = 1'b0;
            next_s.conv_cnt = s.conv_cnt + 8'h01;
            if (conv_end) begin
               next_s.converting = 1'b0;
               next_s.seen = edge_cnt;
               next_s.shifted = acr_pkg::EDGE_RESET;
               if (s.mode_cs) begin
                  next_s.busy = sel;
                  if (sel) begin
                     // start bit low: a pulled-up line sees a falling edge
                     next_s.word = {1'b0, conv_data};
                     next_s.oe = 1'b1;
                     next_s.out = 1'b0;
                     next_s.st = acr_pkg::ST_SHIFT;
                  end else begin
                     next_s.word = {conv_data, 1'b0};
                     next_s.st = acr_pkg::ST_WAIT_SEL;
                  end
               end else begin
                  next_s.busy = s.chain_busy;
                  if (s.chain_busy) begin
                     // only this converter's completion is visible here
                     next_s.word = {1'b1, conv_data};
                     next_s.out = 1'b1;
                  end else begin
                     next_s.word = {conv_data, 1'b0};
                     next_s.out = conv_data[acr_pkg::RESULT_BITS-1];
                  end
                  next_s.oe = 1'b1;
                  next_s.st = acr_pkg::ST_SHIFT;
               end
            end
         end
         acr_pkg::ST_WAIT_SEL: begin
            next_s.oe = 1'b0;
            if (sel) begin
               next_s.seen = edge_cnt;
               next_s.shifted = acr_pkg::EDGE_RESET;
               next_s.oe = 1'b1;
               next_s.out = s.word[acr_pkg::WORD_MSB];
               next_s.st = acr_pkg::ST_SHIFT;
            end
         end
         acr_pkg::ST_SHIFT: begin
            if (s.mode_cs && !sel) begin
               next_s.oe = 1'b0;
               next_s.st = acr_pkg::ST_IDLE;
            end else if (!s.mode_cs && !cnv) begin
               next_s.oe = !sdi;
               next_s.out = 1'b0;
               next_s.st = acr_pkg::ST_IDLE;
            end else if (step) begin
               next_s.seen = s.seen + 6'h01;
               next_s.shifted = s.shifted + 6'h01;
               // without a start bit the word sits one place high: chain data
               // enters above the spare low bit so it follows d0 with no gap
               if (s.busy) begin
                  next_s.word = {s.word[acr_pkg::WORD_MSB-1:0], chain_bit};
               end else begin
                  next_s.word = {s.word[acr_pkg::WORD_MSB-1:1], chain_bit, 1'b0};
               end
               next_s.out = s.word[acr_pkg::WORD_MSB-1];
               if (s.mode_cs && (s.shifted + 6'h01 == limit)) begin
                  next_s.oe = 1'b0;
                  next_s.st = acr_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            next_s = REGS_RESET;
         end
      endcase
      // a new conversion cannot be restarted while one is running
      if (cnv_rise && s.st != acr_pkg::ST_CONVERT) begin
         next_s.mode_cs = sdi;
         next_s.chain_busy = sck_level;
         next_s.conv_cnt = acr_pkg::CONV_CNT_RESET;
         next_s.converting = 1'b1;
         next_s.oe = 1'b0;
         next_s.st = acr_pkg::ST_CONVERT;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s <= REGS_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign serial_result_out = s.out;
   assign serial_result_oe = s.oe;
   assign converting = s.converting;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking chk_cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   logic [acr_pkg::CONV_CNT_BITS-1:0] conv_age;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         conv_age <= acr_pkg::CONV_CNT_RESET;
      end else if (s.st == acr_pkg::ST_CONVERT) begin
         conv_age <= conv_age + 8'h01;
      end else begin
         conv_age <= acr_pkg::CONV_CNT_RESET;
      end
   end

   sequence start_seen;
      cnv_rise && s.st != acr_pkg::ST_CONVERT;
   endsequence

   sequence cs_done;
      conv_end && s.mode_cs;
   endsequence

   start_hiz_a: assert property (start_seen |=> s.st == acr_pkg::ST_CONVERT && !s.oe)
      else $error("conversion start did not release the output");
   mode_latch_a: assert property (start_seen |=> s.mode_cs == $past(sdi))
      else $error("mode not taken from select level");
   conv_hiz_a: assert property (s.st == acr_pkg::ST_CONVERT |-> !s.oe && s.converting)
      else $error("output driven during conversion");
   conv_len_a: assert property ($fell(s.st == acr_pkg::ST_CONVERT) && !$past(cnv_rise)
      |-> $past(conv_age) == acr_pkg::CONV_LAST)
      else $error("conversion length wrong");
   busy_start_a: assert property ((cs_done and sel) |=> s.oe && !s.out && s.busy)
      else $error("busy start bit missing");
   no_busy_a: assert property ((cs_done and !sel) |=> !s.oe ##1 !s.oe)
      else $error("output driven without busy or selection");
   chain_msb_a: assert property (conv_end && !s.mode_cs && !s.chain_busy
      |=> s.oe && s.out == $past(conv_data[acr_pkg::RESULT_BITS-1]))
      else $error("chain msb not shown at completion");
   drive_low_a: assert property (s.st == acr_pkg::ST_IDLE && !cnv && !sdi |=> s.oe && !s.out)
      else $error("both lines low but output not low");
   shift_msb_a: assert property (s.st == acr_pkg::ST_SHIFT && step && sel && cnv
      |=> s.out == $past(s.word[acr_pkg::WORD_MSB-1]))
      else $error("shifted bit out of order");
   edge_limit_a: assert property (s.st == acr_pkg::ST_SHIFT && s.mode_cs && sel && step
      && s.shifted == limit - 6'h01 |=> !s.oe)
      else $error("output still driven after last edge");
   deselect_a: assert property (s.st == acr_pkg::ST_SHIFT && s.mode_cs && !sel |=> !s.oe)
      else $error("output still driven after deselection");
endmodule : acr_readout

// ==== verilog/acr_sync.sv ====
// two-stage synchroniser for levels and gray-coded words
// assumes each bit of d may change at any time relative to clock
`timescale 1ns/100ps
module acr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // first stage is read only by the second stage
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : acr_sync
